/* File: dv/aicsel_host.sv */
// host model that writes the control register
`timescale 1ns/1ns
module aicsel_host (
  input wire logic clock,
  output logic ctrl_write,
  output logic input_config_bit_low,
  output logic input_config_bit_high,
  output logic auto_scan_select,
  output logic channel_mask_select,
  output logic [2:0] channel_pointer
);
  // one write; fields show a changed pattern once released
  task automatic write(input logic [1:0] cf, sq, input logic [2:0] pt);
    @(posedge clock);
    ctrl_write <= 1'b1;
    {input_config_bit_high, input_config_bit_low, auto_scan_select,
      channel_mask_select, channel_pointer} <= {cf, sq, pt};
    @(posedge clock);
    ctrl_write <= 1'b0;
    {input_config_bit_high, input_config_bit_low, auto_scan_select,
      channel_mask_select, channel_pointer} <= ~{cf, sq, pt};
  endtask
  initial {ctrl_write, input_config_bit_low, input_config_bit_high,
    auto_scan_select, channel_mask_select, channel_pointer} = 8'h00;
endmodule

/* File: dv/aicsel_props.sv */
// assertions on the ports of the channel select block
`timescale 1ns/1ns
module aicsel_props #(
  parameter int CODE_WIDTH = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ctrl_write,
  input wire logic auto_scan_select,
  input wire logic channel_mask_select,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic converting,
  input wire logic [7:0] positive_analog_input,
  input wire logic [7:0] negative_analog_input,
  input wire logic neg_ground_tie,
  input wire logic differential_coding,
  input wire logic traditional_mode,
  input wire logic [1:0] active_config,
  input wire logic [2:0] active_channel
);
  wire logic [7:0] p = positive_analog_input;
  wire logic [7:0] n = negative_analog_input;
  wire logic [2:0] c = active_channel;
  wire logic [1:0] g = active_config;
  logic st_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // marks the cycle after an accepted start
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) st_reg <= 1'b0;
    else st_reg <= conv_start && !converting;
  property p_single;
    st_reg && g == 2'h0 |=> neg_ground_tie && p == 8'h01 << c && n == 8'h00;
  endproperty
  a_single: assert property (p_single) else $error("bad single");
  property p_diff;
    st_reg && g == 2'h2 |=> differential_coding
      && p == 8'h01 << {c[1:0], 1'b0} && n == p << 1;
  endproperty
  a_diff: assert property (p_diff) else $error("bad diff");
  property p_pair;
    st_reg && g == 2'h1 |=> !differential_coding
      && n == 8'h02 << {c[1:0], 1'b0} && p == n >> 1;
  endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
  property p_seven;
    st_reg && g == 2'h3 && c != 3'h7 |=> n == 8'h80 && p == 8'h01 << c;
  endproperty
  a_seven: assert property (p_seven) else $error("bad seven");
  property p_trad;
    ctrl_write |=> traditional_mode == !$past(auto_scan_select
      || channel_mask_select);
  endproperty
  a_trad: assert property (p_trad) else $error("bad mode");
  property p_hold;
    converting && !st_reg |=> $stable(p) && $stable(c) && $stable(g);
  endproperty
  a_hold: assert property (p_hold) else $error("bad hold");
  property p_start;
    conv_start && !converting |=> converting;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_done;
    conv_done && converting |=> !converting;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  c_diff: cover property (st_reg && g == 2'h2);
  c_seven: cover property (st_reg && g == 2'h3);
  c_single: cover property (st_reg && g == 2'h0);
  c_pair: cover property (st_reg && g == 2'h1);
endmodule
bind aicsel_top aicsel_props #(.CODE_WIDTH(CODE_WIDTH)) props_inst (.*);

/* File: dv/testbench.sv */
// self-checking bench for the channel select block
`timescale 1ns/1ns
module testbench;
  logic clock, rst_b, ctrl_write, input_config_bit_low, input_config_bit_high;
  logic auto_scan_select, channel_mask_select, conv_start, conv_done;
  logic neg_ground_tie, differential_coding, traditional_mode, converting;
  logic [7:0] positive_analog_input, negative_analog_input;
  logic [11:0] full_scale_code;
  logic [2:0] channel_pointer, active_channel, pch;
  logic [1:0] active_config, pcfg;
  logic conv_reg, rise_reg, ptrad;
  logic [35:0] got, e, exp_q[$];
  logic [31:0] r;
  integer seed = 32'hecb7, fail_count = 0, compares = 0, cyc = 0, i;
  aicsel_host aicsel_host_inst (.*);
  aicsel_top aicsel_top_inst (.*);
  // clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // selects for an arrangement and pointer
  function automatic logic [15:0] sel(input logic [1:0] c,
    input logic [2:0] p);
    logic [7:0] q;
    q = 8'h01 << {p[1:0], 1'b0};
    case (c)
      2'h0: sel = {8'h01 << p, 8'h00};
      2'h3: sel = p == 3'h7 ? 16'h0000 : {8'h01 << p, 8'h80};
      default: sel = {q, q << 1};
    endcase
  endfunction
  // one control write, noting what will be pending
  task automatic put(input logic [31:0] v);
    logic [1:0] s;
    s = v[6:5] != 2'h0 ? 2'h0 : v[3:2];
    aicsel_host_inst.write(v[1:0], s, v[9:7]);
    pcfg = v[1:0];
    if (s == 2'h0) pch = v[9:7];
    ptrad = (s == 2'h0);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // checks each new selection against the oldest note
  always @(posedge clock) begin
    conv_reg <= converting;
    rise_reg <= converting && !conv_reg;
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      conclude();
    end else if (rise_reg) begin
      compares++;
      e = exp_q.pop_front();
      got = {active_config, active_channel, positive_analog_input,
        negative_analog_input, full_scale_code, neg_ground_tie,
        differential_coding, traditional_mode};
      if (got !== e) begin
        fail_count++;
        $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
    end
  end
  // start, after a write when r[10] is set, then rewrite and restart while busy
  initial begin
    {rst_b, conv_start, conv_done, pcfg, pch} = 8'h00;
    ptrad = 1'b1;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      if (r[10]) put(r);
      else @(posedge clock);
      conv_start <= 1'b1;
      exp_q.push_back({pcfg, pch, sel(pcfg, pch), 12'hFFF,
        pcfg == 2'h0, pcfg == 2'h2, ptrad});
      @(posedge clock);
      conv_start <= 1'b0;
      put(r >> 11);
      conv_start <= 1'b1;
      @(posedge clock);
      conv_start <= 1'b0;
      conv_done <= 1'b1;
      @(posedge clock);
      conv_done <= 1'b0;
      @(posedge clock);
      $display("test %0d done", i);
    end
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule

/* File: logic/aicsel_pkg.sv */
// shared constants and types for the input configuration and channel select
package aicsel_pkg;
  localparam int ADDR_WIDTH = 3;
  localparam int CHAN_COUNT = 8;
  localparam int CODE_WIDTH_12 = 12;
  localparam int CODE_WIDTH_10 = 10;
  localparam int CODES_12 = 4096;
  localparam int CODES_10 = 1024;
  localparam logic [2:0] SHARED_REF_CHAN = 3'h7;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [7:0] MUX_NONE = 8'h00;

  // input arrangement, coded as {high bit, low bit}
  typedef enum logic [1:0] {
    AICSEL_SINGLE = 2'b00,
    AICSEL_DIFF = 2'b10,
    AICSEL_PSEUDO4 = 2'b01,
    AICSEL_PSEUDO7 = 2'b11
  } aicsel_cfg_t;

  // conversion control states
  typedef enum logic [1:0] {
    AICSEL_IDLE = 2'b00,
    AICSEL_CONV = 2'b01
  } aicsel_state_t;
endpackage

/* File: logic/aicsel_route.sv */
// routing decoder: arrangement and pointer to positive and negative selects
`timescale 1ns/1ns
module aicsel_route (
  input wire logic [1:0] cfg,
  input wire logic [2:0] pointer,
  output logic [7:0] pos_sel,
  output logic [7:0] neg_sel,
  output logic neg_to_ground
);
  import aicsel_pkg::*;

  // pair base channel for differential and four-pair pseudo arrangements
  wire [2:0] pair_pos = {pointer[1:0], 1'b0};
  wire [2:0] pair_neg = {pointer[1:0], 1'b1};
  wire [2:0] pos_idx = (cfg == AICSEL_DIFF || cfg == AICSEL_PSEUDO4) ?
                       pair_pos : pointer;
  wire is_single = (cfg == AICSEL_SINGLE);
  wire is_pseudo7 = (cfg == AICSEL_PSEUDO7);
  // pointer seven has no partner in the seven-input arrangement
  wire p7_bad = is_pseudo7 && (pointer == SHARED_REF_CHAN);

  // one-hot selects for the analog multiplexer
  always_comb begin
    pos_sel = MUX_NONE;
    neg_sel = MUX_NONE;
    neg_to_ground = 1'b0;
    if (is_single) begin
      pos_sel[pointer] = 1'b1;
      neg_to_ground = 1'b1;
    end else if (is_pseudo7) begin
      if (!p7_bad) begin
        pos_sel[pointer] = 1'b1;
        neg_sel[SHARED_REF_CHAN] = 1'b1;
      end
    end else begin
      pos_sel[pos_idx] = 1'b1;
      neg_sel[pair_neg] = 1'b1;
    end
  end
endmodule

/* File: logic/aicsel_top.sv */
// input configuration decode and channel select control of the converter
// Functional notes
// - both config bits zero: eight single-ended, ground
// - bits low 0 high 1: four differential pairs
// - 1,0 four pseudo pairs; 1,1 seven pseudo
// - seven-input mode uses input seven as reference
// - differential span maps across full code range
// - both sequencing bits clear: traditional multichannel
// - each control write with both sequencing bits clear sets the next conversion's channel
`timescale 1ns/1ns
module aicsel_top #(
  parameter int CODE_WIDTH = aicsel_pkg::CODE_WIDTH_12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ctrl_write,
  input wire logic input_config_bit_low,
  input wire logic input_config_bit_high,
  input wire logic auto_scan_select,
  input wire logic channel_mask_select,
  input wire logic [aicsel_pkg::ADDR_WIDTH-1:0] channel_pointer,
  input wire logic conv_start,
  input wire logic conv_done,
  output logic [7:0] positive_analog_input,
  output logic [7:0] negative_analog_input,
  output logic neg_ground_tie,
  output logic differential_coding,
  output logic [CODE_WIDTH-1:0] full_scale_code,
  output logic traditional_mode,
  output logic [1:0] active_config,
  output logic [2:0] active_channel,
  output logic converting
);
  import aicsel_pkg::*;

  logic [1:0] pend_cfg_reg;
  logic [1:0] pend_cfg_next;
  logic [2:0] pend_ptr_reg;
  logic [2:0] pend_ptr_next;
  logic trad_reg;
  logic trad_next;
  logic [1:0] act_cfg_reg;
  logic [2:0] act_ptr_reg;
  aicsel_state_t state_reg;
  aicsel_state_t state_next;
  logic [7:0] pos_sel;
  logic [7:0] neg_sel;
  logic neg_gnd;

  // both sequencing bits clear means a traditional write
  function automatic logic seq_is_trad(input logic scan,
    input logic mask);
    return ~scan & ~mask;
  endfunction

  // true for the fully differential arrangement
  function automatic logic cfg_is_diff(input logic [1:0] cfg);
    return cfg == AICSEL_DIFF;
  endfunction

  // number of codes across the span, by converter width
  localparam int SPAN_CODES = (CODE_WIDTH == CODE_WIDTH_10) ? CODES_10 :
                              CODES_12;

  // write decode; the pointer only steers in traditional mode
  wire wr_trad = seq_is_trad(auto_scan_select, channel_mask_select);
  wire ptr_take = ctrl_write && wr_trad;
  wire [1:0] wr_cfg = {input_config_bit_high, input_config_bit_low};
  wire start_ok = conv_start && (state_reg == AICSEL_IDLE);

  // a start in the write cycle already sees the new settings
  wire [1:0] start_cfg = ctrl_write ? wr_cfg : pend_cfg_reg;
  wire [2:0] start_ptr = ptr_take ? channel_pointer : pend_ptr_reg;

  // sequencing status follows each write
  assign trad_next = ctrl_write ? wr_trad : trad_reg;

  // pending arrangement follows every control write, pending pointer only traditional writes
  always_comb begin
    pend_cfg_next = pend_cfg_reg;
    pend_ptr_next = pend_ptr_reg;
    if (ctrl_write) begin
      pend_cfg_next = wr_cfg;
    end
    if (ptr_take) begin
      pend_ptr_next = channel_pointer;
    end
  end

  // conversion tracking
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AICSEL_IDLE: begin
        if (conv_start) begin
          state_next = AICSEL_CONV;
        end
      end
      AICSEL_CONV: begin
        if (conv_done) begin
          state_next = AICSEL_IDLE;
        end
      end
      default: state_next = AICSEL_IDLE;
    endcase
  end

  // pending arrangement register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_cfg_reg <= CFG_RESET;
    end else begin
      pend_cfg_reg <= pend_cfg_next;
    end
  end

  // pending pointer; refused writes leave it as it was
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_ptr_reg <= CHAN_RESET;
    end else begin
      pend_ptr_reg <= pend_ptr_next;
    end
  end

  // sequencing status of the last write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trad_reg <= 1'b1;
    end else begin
      trad_reg <= trad_next;
    end
  end

  // conversion state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= AICSEL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // arrangement in force latches only at an accepted start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_cfg_reg <= CFG_RESET;
    end else if (start_ok) begin
      act_cfg_reg <= start_cfg;
    end
  end

  // pointer in force latches only at an accepted start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_ptr_reg <= CHAN_RESET;
    end else if (start_ok) begin
      act_ptr_reg <= start_ptr;
    end
  end

  aicsel_route u_route (
    .cfg(act_cfg_reg),
    .pointer(act_ptr_reg),
    .pos_sel(pos_sel),
    .neg_sel(neg_sel),
    .neg_to_ground(neg_gnd)
  );

  // arrangement in force codes a signed span
  wire act_is_diff = cfg_is_diff(act_cfg_reg);

  // positive mux drive
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      positive_analog_input <= MUX_NONE;
    end else begin
      positive_analog_input <= pos_sel;
    end
  end

  // negative mux drive
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      negative_analog_input <= MUX_NONE;
    end else begin
      negative_analog_input <= neg_sel;
    end
  end

  // ground tie of the negative side
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      neg_ground_tie <= 1'b1;
    end else begin
      neg_ground_tie <= neg_gnd;
    end
  end

  // differential coding flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      differential_coding <= 1'b0;
    end else begin
      differential_coding <= act_is_diff;
    end
  end

  // full span of codes ends at the last code of the width
  assign full_scale_code = CODE_WIDTH'(SPAN_CODES - 1);

  // sequencing status seen by the host
  assign traditional_mode = trad_reg;

  // settings in force for the running conversion
  assign active_config = act_cfg_reg;
  assign active_channel = act_ptr_reg;

  // busy while a conversion runs
  assign converting = (state_reg == AICSEL_CONV);
endmodule
